// ===== clf_defs.svh
// Purpose: Register indexes, field positions and input numbering for the
//          custom logic block.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only, shared by the two design modules.
`ifndef CLF_DEFS_SVH
`define CLF_DEFS_SVH

// Register indexes (byte address = index * 4)
`define CLF_IDX_CTRLA      8'h00
`define CLF_IDX_SEQCTRL    8'h01
`define CLF_IDX_LUT_BASE   8'h05
`define CLF_IDX_LUT_STEP   8'h04
`define CLF_IDX_STATUS     8'h10
`define CLF_IDX_NONE       8'hFF

// Offsets of a table's registers from its base index
`define CLF_LUT_OFF_A      8'h00
`define CLF_LUT_OFF_B      8'h01
`define CLF_LUT_OFF_C      8'h02
`define CLF_LUT_OFF_TRUTH  8'h03

// Field positions
`define CLF_BIT_EN         0
`define CLF_BIT_RUNSTDBY   6
`define CLF_BIT_EDGE       7
`define CLF_BIT_CLKSEL     6
`define CLF_FILT_HI        5
`define CLF_FILT_LO        4
`define CLF_BIT_OUTEN      3

// Numbering of the asynchronous inputs after synchronisation
`define CLF_PINS_PER_TABLE 3
`define CLF_AIN_EVENT_A    6
`define CLF_AIN_EVENT_B    7
`define CLF_AIN_PERIPH     8

`endif

// ===== clf_pkg.sv
// Purpose: Types of the custom logic block.
// Assumes: Enum values follow the order of the field encodings.
// Notes:   All state of each design module is one packed struct from here.
package clf_pkg;

  typedef enum logic [3:0] {
    CLF_SEQUENCER_OFF,
    CLF_SEQUENCER_GATED_D_FLOP,
    CLF_SEQUENCER_SET_RESET_TOGGLE_FLOP,
    CLF_SEQUENCER_GATED_TRANSPARENT_LATCH,
    CLF_SEQUENCER_SET_CLEAR_LATCH
  } clf_sequencer_e;

  typedef enum logic [1:0] {
    CLF_FILTER_OFF,
    CLF_FILTER_SYNCHRONISER,
    CLF_FILTER_SPIKE,
    CLF_FILTER_RESERVED
  } clf_filter_e;

  typedef enum logic [3:0] {
    CLF_IN_MASK,
    CLF_IN_FEEDBACK,
    CLF_IN_LINK,
    CLF_IN_EVENT_A,
    CLF_IN_EVENT_B,
    CLF_IN_PIN,
    CLF_IN_PERIPH0,
    CLF_IN_PERIPH1,
    CLF_IN_PERIPH2,
    CLF_IN_PERIPH3
  } clf_insel_e;

  typedef struct packed {
    logic       edge_detect_on;
    logic       table_clock_select;
    logic [1:0] output_filter_select;
    logic       outen;
    logic       enable;
    logic [3:0] table_input2_select;
    logic [3:0] table_input1_select;
    logic [3:0] table_input0_select;
    logic [7:0] truth_value;
  } clf_table_cfg_s;

  typedef struct packed {
    logic                 glob_en;
    logic                 runstdby;
    logic [3:0]           sequencer_function_select;
    clf_table_cfg_s [1:0] tab;
    logic [11:0]          sync1;
    logic [11:0]          sync2;
    logic [11:0]          sync3;
    logic [11:0]          stab;
    logic [1:0]           in2_prev;
    logic [1:0]           lut_raw;
    logic                 sequencer_q;
    logic                 clear_hold;
    logic                 dphase;
    logic                 dwrite;
    logic                 rd_pend;
    logic [7:0]           didx;
    logic [31:0]          hrdata;
    logic                 hreadyout;
    logic                 hresp;
    logic [1:0]           table_out;
    logic [1:0]           table_out_oe;
  } clf_state_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic filt;
    logic edge_prev;
    logic pulse;
  } clf_stage_s;

endpackage

// ===== clf_table_stage.sv
// Purpose: Output stage of one table: synchroniser, spike filter, edge pulse.
// Assumes: tick marks a rising edge of the table clock, high every cycle
//          when the table runs on the bus clock.
// Notes:   Reserved filter code behaves as filter off.
`timescale 1ns/1ps
`include "clf_defs.svh"
module clf_table_stage (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       enable,
  input  wire logic       tick,
  input  wire logic [1:0] output_filter_select,
  input  wire logic       edge_detect_on,
  input  wire logic       raw,
  output logic            stage_out
);
  clf_pkg::clf_stage_s q;
  clf_pkg::clf_stage_s nxt;
  logic                mid;

  // Last enabled stage before the edge detector
  assign mid = (output_filter_select == clf_pkg::CLF_FILTER_SYNCHRONISER)
               ? q.s2
               : (output_filter_select == clf_pkg::CLF_FILTER_SPIKE)
               ? q.filt : raw;
  assign stage_out = edge_detect_on ? q.pulse : mid;

  // Pipeline advances only on table clock edges
  always_comb begin
    nxt = q;
    if (!enable) begin
      nxt = '0;
    end else if (tick) begin
      nxt.s1 = raw;
      nxt.s2 = q.s1;
      nxt.s3 = q.s2;
      // Three equal samples before the gated flop takes the value
      if (q.s1 == q.s2 && q.s2 == q.s3) begin
        nxt.filt = q.s3;
      end
      nxt.edge_prev = mid;
      nxt.pulse     = mid & ~q.edge_prev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= nxt;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sync_delay_a: assert property (
    (enable && tick &&
     output_filter_select == clf_pkg::CLF_FILTER_SYNCHRONISER) [*2]
    |-> q.s2 == $past(raw, 2))
    else $error("synchroniser delay is not two edges");

  spike_delay_a: assert property (
    (enable && tick && $stable(raw) &&
     output_filter_select == clf_pkg::CLF_FILTER_SPIKE) [*5]
    |-> q.filt == $past(raw, 4))
    else $error("filter output is not the input four edges back");

  stage_clear_a: assert property (
    !enable |=> (q == '0))
    else $error("stage state not cleared after disable");

  edge_pulse_a: assert property (
    (enable && tick && mid && !q.edge_prev) |=> q.pulse)
    else $error("rising edge gave no pulse");
endmodule

// ===== clf_custom_logic_block.sv
// Purpose: Two three-input tables with output stages and a shared pair
//          sequencer, configured over an AHB-Lite slave.
// Assumes: 100 MHz hclk; pins, events and peripheral lines are asynchronous.
// Notes:   Reads take one wait state so they always see the last write.
// How it works
// - Pair configuration other than truth values and enable bits changes only while the even table is off.
// - Protected bits go in with enable-to-one, or with enable-to-zero only to a table already off.
// - Global enable bit switches the whole block on and off.
// - Each table has its own on/off bit.
// - Output is truth bit indexed by inputs, input 2 most significant.
// - Masked or unused inputs read as low.
// - Feedback input gives the pair sequencer output to both tables.
// - Link input gives the next table's output, wrapping to table zero.
// - Two event lines are selectable inputs; route events first.
// - Pin input takes the pin tied to that table and input index.
// - With no filter the output follows the table logic directly.
// - Synchroniser delays the output by two table clock edges.
// - Filter passes values held over three edges, delay four edges.
// - Filter and edge state clear one cycle after table switch-off.
// - Edge detector pulses on rising edges; invert truth for falling.
// - One sequencer per pair, function set by the select field.
// - Sequencer takes the last enabled stage of each table path.
// - Sequencer flops run on the even table's clock, rising edge; latches on every bus clock.
// - Even table off clears the sequencer, clear held one cycle.
// - Gated D flop: capture D while gate high, else hold.
// - J/K: hold, clear, set, toggle on each clock edge.
// - Gated latch follows D while gate high, holds when low.
// - Set/clear latch: hold, clear, set; both high forbidden.
// - Select codes: off, D flop, J/K, D latch, set/clear latch.
// - Filter codes: off, synchroniser, filter, reserved.
// - Clock select makes input 2 the table clock, low in truth.
`timescale 1ns/1ps
`include "clf_defs.svh"
module clf_custom_logic_block (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [5:0]  table_pin_in,
  input  wire logic        event_line_a,
  input  wire logic        event_line_b,
  input  wire logic [3:0]  periph_in,
  output logic      [1:0]  table_out,
  output logic      [1:0]  table_out_oe,
  output logic             pair_sequencer_output
);
  clf_pkg::clf_state_s q;
  clf_pkg::clf_state_s nxt;
  logic [11:0]         ain;
  logic [1:0]          eff_en;
  logic [1:0]          tick;
  logic [1:0]          stage_out;
  logic [1:0]          lut_now;

  // Index of a table register, used by both read and write decode
  function automatic logic [7:0] idx_of(input int n, input logic [7:0] off);
    idx_of = 8'(`CLF_IDX_LUT_BASE + 8'(n) * `CLF_IDX_LUT_STEP + off);
  endfunction

  // Input select field of one table input
  function automatic logic [3:0] insel_of(
    input clf_pkg::clf_table_cfg_s c, input int i);
    insel_of = (i == 0) ? c.table_input0_select
             : (i == 1) ? c.table_input1_select : c.table_input2_select;
  endfunction

  // Source of one table input; unknown codes fall to low
  function automatic logic pick_input(
    input logic [3:0] sel, input int n, input int i,
    input logic [11:0] stab, input logic fb, input logic link);
    pick_input = 1'b0;
    case (sel)
      clf_pkg::CLF_IN_FEEDBACK: pick_input = fb;
      clf_pkg::CLF_IN_LINK:     pick_input = link;
      clf_pkg::CLF_IN_EVENT_A:  pick_input = stab[`CLF_AIN_EVENT_A];
      clf_pkg::CLF_IN_EVENT_B:  pick_input = stab[`CLF_AIN_EVENT_B];
      clf_pkg::CLF_IN_PIN:
        pick_input = stab[n * `CLF_PINS_PER_TABLE + i];
      clf_pkg::CLF_IN_PERIPH0:  pick_input = stab[`CLF_AIN_PERIPH];
      clf_pkg::CLF_IN_PERIPH1:  pick_input = stab[`CLF_AIN_PERIPH + 1];
      clf_pkg::CLF_IN_PERIPH2:  pick_input = stab[`CLF_AIN_PERIPH + 2];
      clf_pkg::CLF_IN_PERIPH3:  pick_input = stab[`CLF_AIN_PERIPH + 3];
      default:                  pick_input = 1'b0;
    endcase
  endfunction

  // Register read decode; unmapped indexes read zero
  function automatic logic [31:0] read_reg(
    input logic [7:0] idx, input clf_pkg::clf_state_s s);
    logic [31:0] r;
    r = '0;
    if (idx == `CLF_IDX_CTRLA) begin
      r[`CLF_BIT_EN]       = s.glob_en;
      r[`CLF_BIT_RUNSTDBY] = s.runstdby;
    end else if (idx == `CLF_IDX_SEQCTRL) begin
      r[3:0] = s.sequencer_function_select;
    end else if (idx == `CLF_IDX_STATUS) begin
      r[4:0] = {s.table_out, s.sequencer_q, s.lut_raw};
    end
    for (int n = 0; n < 2; n++) begin
      if (idx == idx_of(n, `CLF_LUT_OFF_A)) begin
        r[`CLF_BIT_EDGE]                  = s.tab[n].edge_detect_on;
        r[`CLF_BIT_CLKSEL]                = s.tab[n].table_clock_select;
        r[`CLF_FILT_HI:`CLF_FILT_LO]      = s.tab[n].output_filter_select;
        r[`CLF_BIT_OUTEN]                 = s.tab[n].outen;
        r[`CLF_BIT_EN]                    = s.tab[n].enable;
      end else if (idx == idx_of(n, `CLF_LUT_OFF_B)) begin
        r[7:0] = {s.tab[n].table_input1_select,
                  s.tab[n].table_input0_select};
      end else if (idx == idx_of(n, `CLF_LUT_OFF_C)) begin
        r[3:0] = s.tab[n].table_input2_select;
      end else if (idx == idx_of(n, `CLF_LUT_OFF_TRUTH)) begin
        r[7:0] = s.tab[n].truth_value;
      end
    end
    read_reg = r;
  endfunction

  assign ain = {periph_in, event_line_b, event_line_a, table_pin_in};

  // Per-table input selection, truth lookup and output stage
  for (genvar n = 0; n < 2; n++) begin : g_tab
    logic [2:0] tin;
    for (genvar i = 0; i < 3; i++) begin : g_in
      assign tin[i] = pick_input(insel_of(q.tab[n], i), n, i, q.stab,
                                 q.sequencer_q, q.lut_raw[(n + 1) % 2]);
    end
    assign eff_en[n] = q.glob_en & q.tab[n].enable;
    // Input 2 as table clock: a rising edge of its settled value
    assign tick[n] = q.tab[n].table_clock_select
                     ? (tin[2] & ~q.in2_prev[n]) : 1'b1;
    assign lut_now[n] = eff_en[n] & q.tab[n].truth_value[
      {tin[2] & ~q.tab[n].table_clock_select, tin[1], tin[0]}];
    clf_table_stage u_stage (
      .hclk                 (hclk),
      .hresetn              (hresetn),
      .enable               (eff_en[n]),
      .tick                 (tick[n]),
      .output_filter_select (q.tab[n].output_filter_select),
      .edge_detect_on       (q.tab[n].edge_detect_on),
      .raw                  (lut_now[n]),
      .stage_out            (stage_out[n])
    );
  end

  // Whole next state: bus, configuration, synchronisers, sequencer, outputs
  always_comb begin
    nxt = q;
    // Three-flop synchroniser; a change counts once stages 2 and 3 agree
    nxt.sync1 = ain;
    nxt.sync2 = q.sync1;
    nxt.sync3 = q.sync2;
    nxt.stab  = (q.stab & (q.sync2 ^ q.sync3))
              | (q.sync3 & ~(q.sync2 ^ q.sync3));
    nxt.in2_prev = {g_tab[1].tin[2], g_tab[0].tin[2]};
    // Registered raw value breaks the loop two linked tables would make
    nxt.lut_raw = lut_now;

    // Bus address phase; reads get one wait state
    nxt.dphase    = 1'b0;
    nxt.rd_pend   = 1'b0;
    nxt.hreadyout = 1'b1;
    nxt.hresp     = 1'b0;
    if (q.rd_pend) begin
      nxt.hrdata = read_reg(q.didx, q);
    end
    if (hsel && htrans[1] && hready) begin
      nxt.dphase = 1'b1;
      nxt.dwrite = hwrite;
      nxt.didx   = (haddr[31:10] == 22'h0) ? haddr[9:2] : `CLF_IDX_NONE;
      if (!hwrite) begin
        nxt.rd_pend   = 1'b1;
        nxt.hreadyout = 1'b0;
      end
    end

    // Write data phase with enable protection of the pair
    if (q.dphase && q.dwrite) begin
      if (q.didx == `CLF_IDX_CTRLA) begin
        nxt.glob_en  = hwdata[`CLF_BIT_EN];
        nxt.runstdby = hwdata[`CLF_BIT_RUNSTDBY];
      end else if (q.didx == `CLF_IDX_SEQCTRL) begin
        if (!q.tab[0].enable) begin
          nxt.sequencer_function_select = hwdata[3:0];
        end
      end
      for (int n = 0; n < 2; n++) begin
        if (q.didx == idx_of(n, `CLF_LUT_OFF_A)) begin
          nxt.tab[n].enable = hwdata[`CLF_BIT_EN];
          // Applied only if the pair is off and this is not a switch-off
          if (!q.tab[0].enable &&
              (hwdata[`CLF_BIT_EN] || !q.tab[n].enable)) begin
            nxt.tab[n].edge_detect_on     = hwdata[`CLF_BIT_EDGE];
            nxt.tab[n].table_clock_select = hwdata[`CLF_BIT_CLKSEL];
            nxt.tab[n].output_filter_select =
              hwdata[`CLF_FILT_HI:`CLF_FILT_LO];
            nxt.tab[n].outen = hwdata[`CLF_BIT_OUTEN];
          end
        end else if (q.didx == idx_of(n, `CLF_LUT_OFF_B)) begin
          if (!q.tab[0].enable) begin
            nxt.tab[n].table_input1_select = hwdata[7:4];
            nxt.tab[n].table_input0_select = hwdata[3:0];
          end
        end else if (q.didx == idx_of(n, `CLF_LUT_OFF_C)) begin
          if (!q.tab[0].enable) begin
            nxt.tab[n].table_input2_select = hwdata[3:0];
          end
        end else if (q.didx == idx_of(n, `CLF_LUT_OFF_TRUTH)) begin
          nxt.tab[n].truth_value = hwdata[7:0];
        end
      end
    end

    // Pair sequencer, flops on the even table's clock, inputs from the stages
    if (!eff_en[0]) begin
      nxt.sequencer_q = 1'b0;
      nxt.clear_hold  = 1'b1;
    end else if (q.clear_hold) begin
      nxt.sequencer_q = 1'b0;
      nxt.clear_hold  = 1'b0;
    end else begin
      case (q.sequencer_function_select)
        clf_pkg::CLF_SEQUENCER_GATED_D_FLOP: begin
          if (tick[0] && stage_out[1]) begin
            nxt.sequencer_q = stage_out[0];
          end
        end
        clf_pkg::CLF_SEQUENCER_SET_RESET_TOGGLE_FLOP: begin
          if (tick[0]) begin
            case ({stage_out[0], stage_out[1]})
              2'b01:   nxt.sequencer_q = 1'b0;
              2'b10:   nxt.sequencer_q = 1'b1;
              2'b11:   nxt.sequencer_q = ~q.sequencer_q;
              default: nxt.sequencer_q = q.sequencer_q;
            endcase
          end
        end
        clf_pkg::CLF_SEQUENCER_GATED_TRANSPARENT_LATCH: begin
          // Latches follow every bus clock, not the table clock
          if (stage_out[1]) begin
            nxt.sequencer_q = stage_out[0];
          end
        end
        clf_pkg::CLF_SEQUENCER_SET_CLEAR_LATCH: begin
          // Forbidden both-high case simply holds
          if (stage_out[0] ^ stage_out[1]) begin
            nxt.sequencer_q = stage_out[0];
          end
        end
        default: nxt.sequencer_q = 1'b0;
      endcase
    end

    // Even output carries the sequencer when one is selected
    nxt.table_out[0] = eff_en[0] &
      ((q.sequencer_function_select != clf_pkg::CLF_SEQUENCER_OFF)
       ? q.sequencer_q : stage_out[0]);
    nxt.table_out[1] = eff_en[1] & stage_out[1];
    for (int n = 0; n < 2; n++) begin
      nxt.table_out_oe[n] = eff_en[n] & q.tab[n].outen;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q           <= '0;
      q.hreadyout <= 1'b1;
    end else begin
      q <= nxt;
    end
  end

  assign hrdata                = q.hrdata;
  assign hreadyout             = q.hreadyout;
  assign hresp                 = q.hresp;
  assign table_out             = q.table_out;
  assign table_out_oe          = q.table_out_oe;
  assign pair_sequencer_output = q.sequencer_q;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  protect_hold_a: assert property (
    (q.dphase && q.dwrite && q.tab[0].enable &&
     q.didx == idx_of(1, `CLF_LUT_OFF_B))
    |=> $stable(q.tab[1].table_input0_select))
    else $error("protected input select changed while pair enabled");

  glob_enable_a: assert property (
    (q.dphase && q.dwrite && q.didx == `CLF_IDX_CTRLA)
    |=> q.glob_en == $past(hwdata[`CLF_BIT_EN]))
    else $error("global enable did not take the written value");

  table_enable_a: assert property (
    (q.dphase && q.dwrite && q.didx == idx_of(0, `CLF_LUT_OFF_A))
    |=> q.tab[0].enable == $past(hwdata[`CLF_BIT_EN]))
    else $error("table enable did not take the written value");

  truth_index_a: assert property (
    (eff_en[1] && !q.tab[1].table_clock_select)
    |=> q.lut_raw[1] == $past(q.tab[1].truth_value[g_tab[1].tin]))
    else $error("table output is not the indexed truth bit");

  link_input_a: assert property (
    (q.tab[0].table_input0_select == clf_pkg::CLF_IN_LINK)
    |-> g_tab[0].tin[0] == q.lut_raw[1])
    else $error("linked input does not carry next table output");

  seq_clear_a: assert property (
    $fell(eff_en[0]) |=> (!q.sequencer_q && q.clear_hold) ##1
    !q.sequencer_q)
    else $error("sequencer not cleared after even table off");

  flop_hold_a: assert property (
    (eff_en[0] && !q.clear_hold && !stage_out[1] &&
     q.sequencer_function_select == clf_pkg::CLF_SEQUENCER_GATED_D_FLOP)
    |=> $stable(q.sequencer_q))
    else $error("gated flop changed with gate low");

  jk_toggle_a: assert property (
    (eff_en[0] && !q.clear_hold && tick[0] && stage_out[0] &&
     stage_out[1] && q.sequencer_function_select ==
     clf_pkg::CLF_SEQUENCER_SET_RESET_TOGGLE_FLOP)
    |=> q.sequencer_q != $past(q.sequencer_q))
    else $error("toggle case did not toggle");

  read_wait_c: cover property (
    hsel && htrans[1] && hready && !hwrite ##1 !hreadyout ##1 hreadyout);
  seq_set_c: cover property (
    eff_en[0] && q.sequencer_function_select != 4'h0 ##1 q.sequencer_q);
  edge_out_c: cover property (
    q.tab[0].edge_detect_on && eff_en[0] ##1 q.table_out[0]);
endmodule

// ===== clf_far_side.sv
// Purpose: Far side model: table pins, two event lines, peripheral lines.
// Assumes: Bench sets one 12-bit source word in the design's input order.
// Notes:   Lines change just after hclk, as unrelated async levels would.
`timescale 1ns/1ps
module clf_far_side (
  input  wire logic        hclk,
  input  wire logic [11:0] src,
  output logic      [5:0]  table_pin_in,
  output logic             event_line_a,
  output logic             event_line_b,
  output logic      [3:0]  periph_in
);
  // Start low so no line floats before the first edge
  initial begin
    {periph_in, event_line_b, event_line_a, table_pin_in} = 12'h000;
  end

  always @(posedge hclk) begin
    {periph_in, event_line_b, event_line_a, table_pin_in} <= src;
  end
endmodule

// ===== clf_custom_logic_block_bench.sv
// Purpose: Self-checking bench for the custom logic block.
// Assumes: One AHB-Lite master, hready tied to the slave's hreadyout.
// Notes:   Edge detection is used only with the synchroniser selected.
`timescale 1ns/1ps
module clf_custom_logic_block_bench;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0]  htrans = '0;
  logic [11:0] src = '0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, pair_sequencer_output;
  logic [1:0]  table_out, table_out_oe;
  logic [5:0]  table_pin_in;
  logic        event_line_a, event_line_b;
  logic [3:0]  periph_in;
  int          n_errors = 0;
  int          n_checks = 0;
  // Select code and the source bit it reads (link reads table 1 pin 0)
  logic [3:0]  codes [9] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                             4'h8, 4'h9};
  int          bits  [9] = '{0, 3, 6, 7, 0, 8, 9, 10, 11};

  // Clock 100 MHz
  always #5 hclk = ~hclk;

  clf_custom_logic_block i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .table_pin_in(table_pin_in),
    .event_line_a(event_line_a), .event_line_b(event_line_b),
    .periph_in(periph_in), .table_out(table_out),
    .table_out_oe(table_out_oe),
    .pair_sequencer_output(pair_sequencer_output)
  );

  clf_far_side i_far (
    .hclk(hclk), .src(src), .table_pin_in(table_pin_in),
    .event_line_a(event_line_a), .event_line_b(event_line_b),
    .periph_in(periph_in)
  );

  // One single word transfer; waits on hready, no assumed latency
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0000_0000); // Slave always answers OKAY
  endtask

  // Pair setup but table 1 input 2: table 0 off first so protected fields take
  task automatic cfg(input logic [7:0] sq, a0, b0, c0, t0, a1, b1, t1);
    bus(1'b1, 8'h05, 32'h0000_0000);
    bus(1'b1, 8'h01, {24'h0, sq});
    bus(1'b1, 8'h09, {24'h0, a1});
    bus(1'b1, 8'h0a, {24'h0, b1});
    bus(1'b1, 8'h0c, {24'h0, t1});
    bus(1'b1, 8'h06, {24'h0, b0});
    bus(1'b1, 8'h07, {24'h0, c0});
    bus(1'b1, 8'h08, {24'h0, t0});
    bus(1'b1, 8'h05, {24'h0, a0});
  endtask

  // Give the input synchronisers and output register time to settle
  task automatic settle;
    repeat (12) @(posedge hclk);
  endtask

  task automatic results;
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole run needs far fewer cycles
  initial begin
    #200000;
    n_errors++;
    results();
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(8'h01, 32'h0000_0000);
    bus(1'b1, 8'h3f, 32'h0000_00ff);
    rdchk(8'h3f, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0001);
    // All three inputs on pins, truth 0x42
    cfg(8'h00, 8'h09, 8'h55, 8'h05, 8'h42, 8'h00, 8'h00, 8'h00);
    settle();
    chk({30'h0, table_out_oe}, 32'h0000_0001);
    for (int v = 0; v < 8; v++) begin
      src <= 12'(v);
      settle();
      chk({31'h0, table_out[0]}, 32'((8'h42 >> v) & 8'h01));
    end
    // Protected writes while table 0 runs are dropped
    bus(1'b1, 8'h06, 32'h0000_0000);
    rdchk(8'h06, 32'h0000_0055);
    bus(1'b1, 8'h01, 32'h0000_0002);
    rdchk(8'h01, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0000);
    settle();
    chk({30'h0, table_out_oe}, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0001);
    // Switch-off write keeps old protected bits; switch-on applies new
    bus(1'b1, 8'h05, 32'h0000_0020);
    rdchk(8'h05, 32'h0000_0008);
    bus(1'b1, 8'h05, 32'h0000_0019);
    rdchk(8'h05, 32'h0000_0019);
    bus(1'b1, 8'h05, 32'h0000_0000);
    rdchk(8'h05, 32'h0000_0018);
    settle();
    chk({30'h0, table_out_oe}, 32'h0000_0000);
    // Every input source except feedback on input 0, table 1 follows its pin 0
    for (int k = 0; k < 9; k++) begin
      cfg(8'h00, 8'h09, {4'h0, codes[k]}, 8'h00, 8'haa,
          8'h09, 8'h05, 8'haa);
      for (int l = 0; l < 2; l++) begin
        src <= 12'(l) << bits[k];
        settle();
        chk({30'h0, table_out},
            {30'h0, l != 0 && k == 1, l != 0 && k != 0});
      end
    end
    // Each sequencer mode: set, hold, clear, set, then switch-off clear
    for (int m = 1; m < 5; m++) begin
      src <= 12'h000;
      cfg(8'(m), 8'h01, 8'h05, 8'h00, 8'haa, 8'h01, 8'h05, 8'haa);
      src <= (m % 2 == 1) ? 12'h009 : 12'h001;
      settle();
      chk({31'h0, pair_sequencer_output}, 32'h0000_0001);
      src <= 12'h000;
      settle();
      chk({31'h0, pair_sequencer_output}, 32'h0000_0001);
      src <= 12'h008;
      settle();
      chk({31'h0, pair_sequencer_output}, 32'h0000_0000);
      src <= (m % 2 == 1) ? 12'h009 : 12'h001;
      settle();
      chk({31'h0, pair_sequencer_output}, 32'h0000_0001);
      bus(1'b1, 8'h05, 32'h0000_0000);
      settle();
      chk({31'h0, pair_sequencer_output}, 32'h0000_0000);
    end
    // Both tables pulse on one event line edge, so the J/K flop toggles
    src <= 12'h000;
    cfg(8'h02, 8'h91, 8'h03, 8'h00, 8'haa, 8'h91, 8'h03, 8'haa);
    for (int e = 0; e < 3; e++) begin
      src <= (e == 1) ? 12'h000 : 12'h040;
      settle();
      chk({31'h0, table_out[0]}, {31'h0, e < 2});
    end
    results();
  end
endmodule
